// File: hw/aux_state_pkg.sv
// Package with constants and types for the sampler auxiliary state loader.
`default_nettype none
package aux_state_pkg;
    // Command header fields: type, subtype and opcode shared by every accepted state command, then per-command sub-opcodes and lengths.
    localparam logic [2:0] CMD_TYPE_PIPE = 3'h3;
    localparam logic [1:0] CMD_SUBTYPE_3D = 2'h3;
    localparam logic [2:0] CMD_OPCODE_STATE = 3'h1;
    localparam logic [7:0] SUB_KEY_RANGE = 8'h04;
    localparam logic [7:0] SUB_PALETTE = 8'h02;
    localparam logic [7:0] SUB_KERNEL = 8'h11;
    localparam logic [7:0] LEN_KEY_RANGE = 8'h02;
    localparam logic [7:0] LEN_KERNEL = 8'h00;
    // Header field positions.
    localparam int HDR_TYPE_LSB = 29;
    localparam int HDR_SUBTYPE_LSB = 27;
    localparam int HDR_OPCODE_LSB = 24;
    localparam int HDR_SUB_LSB = 16;
    localparam int KEY_INDEX_LSB = 30;
    localparam int KERNEL_W_LSB = 3;
    localparam int KERNEL_H_LSB = 0;
    // Register byte offsets on the bus.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_KERNEL = 8'h0c;
    // Control register bit positions and reset value.
    localparam int CTRL_FLOAT_BIT = 0;
    localparam int CTRL_MONO_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // Reset values of stored state.
    localparam logic [2:0] KERNEL_RESET = 3'h1;
    localparam logic [31:0] KEY_LOW_RESET = 32'h0000_0000;
    localparam logic [31:0] KEY_HIGH_RESET = 32'hffff_ffff;
    // Border record layout: word indices of each representation.
    localparam int BREC_WORDS = 12;
    localparam int BREC_UNSIGNED_NORM_8BIT = 0;
    localparam int BREC_FLOAT32 = 1;
    localparam int BREC_FLOAT16 = 5;
    localparam int BREC_UNORM16 = 7;
    localparam int BREC_SNORM16 = 9;
    localparam int BREC_SIGNED_NORM_8BIT = 11;
    // Value of one for a missing alpha, per representation.
    localparam logic [31:0] ONE_FLOAT32 = 32'h3f80_0000;
    localparam logic [31:0] ONE_FLOAT16 = 32'h0000_3c00;
    localparam logic [31:0] ONE_UNORM16 = 32'h0000_ffff;
    localparam logic [31:0] ONE_SNORM16 = 32'h0000_7fff;
    localparam logic [31:0] ONE_UNSIGNED_NORM_8BIT = 32'h0000_00ff;
    localparam logic [31:0] ONE_SIGNED_NORM_8BIT = 32'h0000_007f;
    localparam int CH_R = 0;
    localparam int CH_A = 3;

    typedef enum logic [2:0] {
        BC_UNSIGNED_NORM_8BIT = 3'h0,
        BC_FLOAT32 = 3'h1,
        BC_FLOAT16 = 3'h2,
        BC_UNORM16 = 3'h3,
        BC_SNORM16 = 3'h4,
        BC_SIGNED_NORM_8BIT = 3'h5
    } border_class_e;

    typedef enum logic [6:0] {
        ST_HDR = 7'h01,
        ST_KEY_IDX = 7'h02,
        ST_KEY_LOW = 7'h04,
        ST_KEY_HIGH = 7'h08,
        ST_PAL = 7'h10,
        ST_KERNEL = 7'h20,
        ST_SKIP = 7'h40
    } parse_state_e;
endpackage
`default_nettype wire

// File: hw/sampler_aux_state_loader.sv
// Sampler auxiliary state: border colour, key ranges, palette, kernel size.
//
// Function
// - Legacy border mode uses 8-bit unsigned normalized border channels.
// - Legacy mode supplies border value even for channels the format lacks.
// - Float mode uses the BORDER_CLASS representation; missing channels give 0, alpha 1.
// - Luminance replicates red to RGB; intensity replicates red to RGBA.
// - Border used outside extent of non-cube surfaces, or on disabled cube faces.
// - Border comes from texture cache; software invalidates that cache.
// - Monochrome filter mode forces the border value to zero.
// - Representation chosen by format and mode; software supplies all.
// - Border record: word0 8-bit, 1-4 float, 5-10 pairs, 11 signed.
// - Key-range command stores low/high into entry from bits 31:30.
// - Texel matches when every component lies inside inclusive bounds.
// - Narrow texel channels widen by copying MSBs into low bits.
// - Signed channels use sign-magnitude bounds; mixed formats all signed.
// - YUV texels lacking chroma use average of left and right chroma.
// - Key layout: A,R,G,B or A,Cr,Y,Cb from high byte to low.
// - Palette load of up to 256 entries always starts at entry 0.
// - Each palette payload word writes one A,R,G,B entry.
// - Paletted textures look up colours in the first palette.
// - Kernel-size command stores width 5:3, height 2:0; size outputs read zero if off.
`default_nettype none
module sampler_aux_state_loader
    import aux_state_pkg::*;
#(
    parameter int PAL_DEPTH = 256,
    parameter int KEY_ENTRIES = 4
) (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic SYS_RST,
    // AHB-Lite register slave.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Border record words returned by the texture cache.
    input wire logic BREC_VALID,
    input wire logic [3:0] BREC_INDEX,
    input wire logic [31:0] BREC_DATA,
    // Border request from the fetch stage.
    input wire logic [2:0] BORDER_CLASS,
    input wire logic [3:0] BORDER_MISSING,
    input wire logic BORDER_LUM,
    input wire logic BORDER_INTENS,
    input wire logic OUT_OF_EXTENT,
    input wire logic CUBE_SURFACE,
    input wire logic FACE_DISABLED,
    output logic USE_BORDER,
    output logic [31:0] BORDER_R,
    output logic [31:0] BORDER_G,
    output logic [31:0] BORDER_B,
    output logic [31:0] BORDER_A,
    // Key range lookup.
    input wire logic KEY_LOOKUP,
    input wire logic [1:0] KEY_ENTRY,
    input wire logic [31:0] KEY_TEXEL,
    input wire logic [15:0] KEY_WIDTHS,
    input wire logic KEY_SIGNED,
    input wire logic KEY_YUV,
    input wire logic KEY_NO_CHROMA,
    input wire logic [31:0] KEY_LEFT,
    input wire logic [31:0] KEY_RIGHT,
    output logic KEY_VALID,
    output logic KEY_MATCH,
    // Palette lookup.
    input wire logic PAL_LOOKUP,
    input wire logic [7:0] PAL_INDEX,
    output logic PAL_VALID,
    output logic [31:0] PAL_COLOR,
    // Monochrome kernel size.
    output logic [2:0] KERNEL_W,
    output logic [2:0] KERNEL_H
);
    parse_state_e state_reg, state_next;
    logic [7:0] remain_reg;
    logic [1:0] key_idx_reg;
    logic [7:0] pal_wr_reg;
    logic [31:0] key_low [KEY_ENTRIES];
    logic [31:0] key_high [KEY_ENTRIES];
    logic [31:0] pal_mem [PAL_DEPTH];
    logic [31:0] brec [BREC_WORDS];
    logic [1:0] ctrl_reg;
    logic [2:0] kern_w_reg, kern_h_reg;
    logic [7:0] acc_cnt_reg, rej_cnt_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic cmd_valid;
    logic [31:0] cmd_word;
    logic hdr_base_ok, hdr_key, hdr_pal, hdr_kern;
    logic [7:0] hdr_len;
    logic addr_phase;
    logic [31:0] rd_value;
    logic [31:0] bsel [4];
    logic [7:0] tx [4];
    logic [7:0] lo [4];
    logic [7:0] hi [4];
    logic [3:0] in_range;

    // Bus slave: zero wait states, always OKAY.
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign addr_phase = HSEL && HTRANS[1] && HREADY;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && HWRITE;
            wr_addr_reg <= HADDR[7:0];
        end
    end

    always_comb begin
        case (HADDR[7:0])
            OFS_CTRL: rd_value = {30'h0, ctrl_reg};
            OFS_STATUS: rd_value = {8'h00, rej_cnt_reg, acc_cnt_reg,
                                    1'b0, state_reg};
            OFS_KERNEL: rd_value = {26'h0, kern_w_reg, kern_h_reg};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_phase && !HWRITE) begin
            HRDATA <= rd_value;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_pend_reg && wr_addr_reg == OFS_CTRL) begin
            ctrl_reg <= HWDATA[1:0];
        end
    end

    // Command words arrive one per write to the command register.
    assign cmd_valid = wr_pend_reg && wr_addr_reg == OFS_CMD;
    assign cmd_word = HWDATA;
    assign hdr_len = cmd_word[7:0];
    assign hdr_base_ok =
        cmd_word[HDR_TYPE_LSB +: 3] == CMD_TYPE_PIPE &&
        cmd_word[HDR_SUBTYPE_LSB +: 2] == CMD_SUBTYPE_3D &&
        cmd_word[HDR_OPCODE_LSB +: 3] == CMD_OPCODE_STATE;
    assign hdr_key = hdr_base_ok && cmd_word[HDR_SUB_LSB +: 8] ==
        SUB_KEY_RANGE && hdr_len == LEN_KEY_RANGE;
    assign hdr_pal = hdr_base_ok &&
        cmd_word[HDR_SUB_LSB +: 8] == SUB_PALETTE;
    assign hdr_kern = hdr_base_ok && cmd_word[HDR_SUB_LSB +: 8] ==
        SUB_KERNEL && hdr_len == LEN_KERNEL;

    always_comb begin
        state_next = state_reg;
        if (cmd_valid) begin
            case (state_reg)
                ST_HDR: begin
                    if (hdr_key) begin
                        state_next = ST_KEY_IDX;
                    end else if (hdr_pal) begin
                        state_next = ST_PAL;
                    end else if (hdr_kern) begin
                        state_next = ST_KERNEL;
                    end else begin
                        state_next = ST_SKIP;
                    end
                end
                ST_KEY_IDX: state_next = ST_KEY_LOW;
                ST_KEY_LOW: state_next = ST_KEY_HIGH;
                ST_KEY_HIGH: state_next = ST_HDR;
                ST_KERNEL: state_next = ST_HDR;
                ST_PAL, ST_SKIP: begin
                    if (remain_reg == 8'h00) begin
                        state_next = ST_HDR;
                    end
                end
                default: state_next = ST_HDR;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state_reg <= ST_HDR;
            remain_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (cmd_valid && state_reg == ST_HDR) begin
                remain_reg <= hdr_len;
            end else if (cmd_valid && remain_reg != 8'h00) begin
                remain_reg <= remain_reg - 8'h01;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            acc_cnt_reg <= 8'h00;
            rej_cnt_reg <= 8'h00;
        end else if (cmd_valid && state_reg == ST_HDR) begin
            if (hdr_key || hdr_pal || hdr_kern) begin
                acc_cnt_reg <= acc_cnt_reg + 8'h01;
            end else begin
                rej_cnt_reg <= rej_cnt_reg + 8'h01;
            end
        end
    end

    // Key table load.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            key_idx_reg <= 2'h0;
            for (int i = 0; i < KEY_ENTRIES; i++) begin
                key_low[i] <= KEY_LOW_RESET;
                key_high[i] <= KEY_HIGH_RESET;
            end
        end else if (cmd_valid) begin
            case (state_reg)
                ST_KEY_IDX: key_idx_reg <= cmd_word[KEY_INDEX_LSB +: 2];
                ST_KEY_LOW: key_low[key_idx_reg] <= cmd_word;
                ST_KEY_HIGH: key_high[key_idx_reg] <= cmd_word;
                default: key_idx_reg <= key_idx_reg;
            endcase
        end
    end

    // Palette load always starts at entry zero.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            pal_wr_reg <= 8'h00;
        end else if (cmd_valid && state_reg == ST_HDR) begin
            pal_wr_reg <= 8'h00;
        end else if (cmd_valid && state_reg == ST_PAL) begin
            pal_wr_reg <= pal_wr_reg + 8'h01;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (cmd_valid && state_reg == ST_PAL) begin
            pal_mem[pal_wr_reg] <= cmd_word;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            PAL_VALID <= 1'b0;
            PAL_COLOR <= 32'h0000_0000;
        end else begin
            PAL_VALID <= PAL_LOOKUP;
            if (PAL_LOOKUP) begin
                PAL_COLOR <= pal_mem[PAL_INDEX];
            end
        end
    end

    // Kernel size is stored always but driven on KERNEL_W/KERNEL_H only while mono is on.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            kern_w_reg <= KERNEL_RESET;
            kern_h_reg <= KERNEL_RESET;
        end else if (cmd_valid && state_reg == ST_KERNEL) begin
            kern_w_reg <= cmd_word[KERNEL_W_LSB +: 3];
            kern_h_reg <= cmd_word[KERNEL_H_LSB +: 3];
        end
    end

    assign KERNEL_W = ctrl_reg[CTRL_MONO_BIT] ? kern_w_reg : 3'h0;
    assign KERNEL_H = ctrl_reg[CTRL_MONO_BIT] ? kern_h_reg : 3'h0;

    // Border record words come only from the texture cache return.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            for (int i = 0; i < BREC_WORDS; i++) begin
                brec[i] <= 32'h0000_0000;
            end
        end else if (BREC_VALID && BREC_INDEX < 4'(BREC_WORDS)) begin
            brec[BREC_INDEX] <= BREC_DATA;
        end
    end

    function automatic logic [31:0] one_of(input logic [2:0] cls);
        case (cls)
            BC_FLOAT32: one_of = ONE_FLOAT32;
            BC_FLOAT16: one_of = ONE_FLOAT16;
            BC_UNORM16: one_of = ONE_UNORM16;
            BC_SNORM16: one_of = ONE_SNORM16;
            BC_SIGNED_NORM_8BIT: one_of = ONE_SIGNED_NORM_8BIT;
            default: one_of = ONE_UNSIGNED_NORM_8BIT;
        endcase
    endfunction

    // Border channel selection: representation, replication, defaults.
    always_comb begin
        logic [2:0] cls;
        logic [31:0] raw [4];
        logic rep;
        rep = 1'b0;
        raw = '{default: 32'h0};
        cls = ctrl_reg[CTRL_FLOAT_BIT] ? BORDER_CLASS : BC_UNSIGNED_NORM_8BIT;
        for (int c = 0; c < 4; c++) begin
            case (cls)
                BC_FLOAT32: raw[c] = brec[BREC_FLOAT32 + c];
                BC_FLOAT16: raw[c] = {16'h0,
                    brec[BREC_FLOAT16 + c / 2][16 * (c % 2) +: 16]};
                BC_UNORM16: raw[c] = {16'h0,
                    brec[BREC_UNORM16 + c / 2][16 * (c % 2) +: 16]};
                BC_SNORM16: raw[c] = {16'h0,
                    brec[BREC_SNORM16 + c / 2][16 * (c % 2) +: 16]};
                BC_SIGNED_NORM_8BIT: raw[c] = {24'h0, brec[BREC_SIGNED_NORM_8BIT][8 * c +: 8]};
                default: raw[c] = {24'h0, brec[BREC_UNSIGNED_NORM_8BIT][8 * c +: 8]};
            endcase
        end
        for (int c = 0; c < 4; c++) begin
            rep = c != CH_R && ((BORDER_LUM && c != CH_A) || BORDER_INTENS);
            bsel[c] = rep ? raw[CH_R] : raw[c];
            if (!rep && ctrl_reg[CTRL_FLOAT_BIT] && BORDER_MISSING[c]) begin
                bsel[c] = (c == CH_A) ? one_of(cls) : 32'h0;
            end
            // Legacy mode keeps the border value for missing channels.
            if (ctrl_reg[CTRL_MONO_BIT]) begin
                bsel[c] = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            USE_BORDER <= 1'b0;
            BORDER_R <= 32'h0000_0000;
            BORDER_G <= 32'h0000_0000;
            BORDER_B <= 32'h0000_0000;
            BORDER_A <= 32'h0000_0000;
        end else begin
            USE_BORDER <= CUBE_SURFACE ? FACE_DISABLED
                                       : OUT_OF_EXTENT;
            BORDER_R <= bsel[0];
            BORDER_G <= bsel[1];
            BORDER_B <= bsel[2];
            BORDER_A <= bsel[3];
        end
    end

    // Key compare path.
    function automatic logic [7:0] widen(input logic [7:0] v,
                                         input logic [3:0] w);
        int k;
        widen = v;
        if (w != 4'h0 && w < 4'h8) begin
            for (int i = 0; i < 8; i++) begin
                k = int'(w) - 1 - (i % int'(w));
                widen[7 - i] = v[k];
            end
        end
    endfunction

    function automatic logic [7:0] sm_to_tc(input logic [7:0] b);
        sm_to_tc = b[7] ? 8'(8'h00 - {1'b0, b[6:0]}) : b;
    endfunction

    always_comb begin
        logic [8:0] avg_cr, avg_cb;
        avg_cr = {1'b0, KEY_LEFT[23:16]} + {1'b0, KEY_RIGHT[23:16]};
        avg_cb = {1'b0, KEY_LEFT[7:0]} + {1'b0, KEY_RIGHT[7:0]};
        for (int c = 0; c < 4; c++) begin
            tx[c] = widen(KEY_TEXEL[8 * c +: 8],
                          KEY_WIDTHS[4 * c +: 4]);
            lo[c] = key_low[KEY_ENTRY][8 * c +: 8];
            hi[c] = key_high[KEY_ENTRY][8 * c +: 8];
        end
        if (KEY_YUV && KEY_NO_CHROMA) begin
            tx[2] = avg_cr[8:1];
            tx[0] = avg_cb[8:1];
        end
        for (int c = 0; c < 4; c++) begin
            if (KEY_SIGNED) begin
                in_range[c] = $signed(tx[c]) >= $signed(sm_to_tc(lo[c])) &&
                    $signed(tx[c]) <= $signed(sm_to_tc(hi[c]));
            end else begin
                in_range[c] = tx[c] >= lo[c] && tx[c] <= hi[c];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            KEY_VALID <= 1'b0;
            KEY_MATCH <= 1'b0;
        end else begin
            KEY_VALID <= KEY_LOOKUP;
            KEY_MATCH <= KEY_LOOKUP && (&in_range);
        end
    end

    // Checks.
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    a_key_high_store: assert property (
        cmd_valid && state_reg == ST_KEY_HIGH |=>
        key_high[$past(key_idx_reg)] == $past(cmd_word))
        else $error("key high value not stored");
    a_key_sequence: assert property (
        cmd_valid && state_reg == ST_HDR && hdr_key |=>
        state_reg == ST_KEY_IDX)
        else $error("key command not followed by index word");
    a_pal_start: assert property (
        cmd_valid && state_reg == ST_HDR && hdr_pal |=> pal_wr_reg == 8'h00)
        else $error("palette load not starting at entry zero");
    a_pal_write: assert property (
        cmd_valid && state_reg == ST_PAL |=>
        pal_mem[$past(pal_wr_reg)] == $past(cmd_word))
        else $error("palette entry not written");
    a_bad_header: assert property (
        cmd_valid && state_reg == ST_HDR && !hdr_base_ok |=>
        state_reg == ST_SKIP)
        else $error("bad header accepted");
    a_mono_border: assert property (
        ctrl_reg[CTRL_MONO_BIT] |=> BORDER_R == 32'h0 && BORDER_A == 32'h0)
        else $error("border not zero in mono mode");
    a_legacy_alpha: assert property (
        !ctrl_reg[1] && !ctrl_reg[0] && !BORDER_INTENS |=>
        BORDER_A == {24'h0, $past(brec[BREC_UNSIGNED_NORM_8BIT][31:24])})
        else $error("legacy alpha not from 8-bit word");
    a_float_missing: assert property (
        ctrl_reg == 2'h1 && BORDER_MISSING[0] && BORDER_CLASS == BC_FLOAT32
        |=> BORDER_R == 32'h0)
        else $error("missing channel not defaulted");
    a_kernel_store: assert property (
        cmd_valid && state_reg == ST_KERNEL ##1 ctrl_reg[CTRL_MONO_BIT] |->
        KERNEL_W == $past(cmd_word[5:3]) && KERNEL_H == $past(cmd_word[2:0]))
        else $error("kernel size not stored");
    a_key_low_match: assert property (
        KEY_LOOKUP && !KEY_SIGNED && !(KEY_YUV && KEY_NO_CHROMA) &&
        KEY_WIDTHS == 16'h0000 &&
        KEY_TEXEL == key_low[KEY_ENTRY] |=> KEY_MATCH)
        else $error("inclusive low bound missed");

    c_key_load: cover property (
        cmd_valid && state_reg == ST_KEY_HIGH);
    c_pal_two: cover property (
        cmd_valid && state_reg == ST_PAL ##1 cmd_valid && state_reg == ST_PAL);
    c_key_hit: cover property (KEY_MATCH);
    c_reject: cover property (cmd_valid && state_reg == ST_SKIP);
endmodule
`default_nettype wire

// File: dv/brec_model.sv
// Texture cache model that returns the border record one word per cycle.
`default_nettype none
module brec_model (
    // Clock and fetch request.
    input wire logic clock,
    input wire logic fill,
    // Record words toward the loader.
    output logic valid,
    output logic [3:0] index,
    output logic [31:0] data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_reg = 5'h0c;
    logic [31:0] word_next;
    always_ff @(posedge clock) begin
        if (fill) begin
            cnt_reg <= 5'h00;
        end else if (cnt_reg != 5'h0c) begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end
    // All six representations come back together in twelve words.
    assign word_next = 32'h4433_2211 + {4{3'h0, cnt_reg}};
    assign valid = cnt_reg != 5'h0c;
    assign index = cnt_reg[3:0];
    // Outside a word the data lines toggle, so stale data cannot pass.
    assign data = valid ? word_next : {32{clock}} ^ 32'h5a5a_5a5a;
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the sampler auxiliary state loader.
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    mismatches++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, fill = 0, hrdy;
    logic lum = 0, ints = 0, oob = 0, cube = 0, fdis = 0, klk = 0, plk = 0;
    logic ub, kv, km, pv, bv, hresp, sgn = 0;
    logic [31:0] haddr = 0, hwdata = 0, tex = 0, hrdata, bd, br, bg, bb;
    logic [31:0] ba, pc;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, cls = 0, kw, kh;
    logic [3:0] miss = 0, bi;
    logic [15:0] wid = 0;
    logic [7:0] pidx = 0;
    int mismatches = 0, num_checks = 0, cyc = 0;
    sampler_aux_state_loader dut (.CLOCK(clk), .SYS_RST(rst), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
        .HRESP(hresp), .BREC_VALID(bv), .BREC_INDEX(bi), .BREC_DATA(bd),
        .BORDER_CLASS(cls), .BORDER_MISSING(miss), .BORDER_LUM(lum),
        .BORDER_INTENS(ints), .OUT_OF_EXTENT(oob), .CUBE_SURFACE(cube),
        .FACE_DISABLED(fdis), .USE_BORDER(ub), .BORDER_R(br),
        .BORDER_G(bg), .BORDER_B(bb), .BORDER_A(ba), .KEY_LOOKUP(klk),
        .KEY_ENTRY(2'h2), .KEY_TEXEL(tex), .KEY_WIDTHS(wid),
        .KEY_SIGNED(sgn), .KEY_YUV(1'h0), .KEY_NO_CHROMA(1'h0),
        .KEY_LEFT(32'h0), .KEY_RIGHT(32'h0), .KEY_VALID(kv),
        .KEY_MATCH(km), .PAL_LOOKUP(plk), .PAL_INDEX(pidx),
        .PAL_VALID(pv), .PAL_COLOR(pc), .KERNEL_W(kw), .KERNEL_H(kh));
    brec_model tcache (.clock(clk), .fill(fill), .valid(bv), .index(bi),
        .data(bd));
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            test_done();
        end
    end
    // One single-word transfer; for a read, d is the expected data.
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= d;
        @(posedge clk);
        while (!hrdy) @(posedge clk);
        `CHK("hresp", 1'h0, hresp)
        if (!w) `CHK("read_data", d, hrdata)
    endtask
    task automatic key(input logic [31:0] t, input logic [15:0] w,
        input logic e);
        @(posedge clk);
        tex <= t;
        wid <= w;
        klk <= 1'h1;
        @(posedge clk);
        klk <= 1'h0;
        #1 `CHK("key_valid", 1'h1, kv)
        `CHK("key_match", e, km)
    endtask
    task automatic pal(input logic [7:0] i, input logic [31:0] e);
        @(posedge clk);
        pidx <= i;
        plk <= 1'h1;
        @(posedge clk);
        plk <= 1'h0;
        #1 `CHK("pal_valid", 1'h1, pv)
        `CHK("pal_color", e, pc)
    endtask
    task automatic brd(input logic [2:0] c, input logic [3:0] m,
        input logic l, input logic i, input logic [31:0] r, g, b, a);
        @(posedge clk);
        cls <= c;
        miss <= m;
        lum <= l;
        ints <= i;
        repeat (2) @(posedge clk);
        #1 `CHK("border", {r, g, b, a}, {br, bg, bb, ba})
    endtask
    task automatic t_kernel();
        bus(1'h0, 8'h00, 32'h0);
        bus(1'h1, 8'h00, 32'h2);
        bus(1'h1, 8'h04, 32'h7911_0000);
        bus(1'h1, 8'h04, 32'h0000_002b);
        @(posedge clk);
        #1 `CHK("kernel", 6'h2b, {kw, kh})
        bus(1'h1, 8'h00, 32'h0);
        @(posedge clk);
        #1 `CHK("kernel_off", 6'h0, {kw, kh})
    endtask
    task automatic t_key();
        // Entry 2 gets bounds with every high at or above its low.
        bus(1'h1, 8'h04, 32'h7904_0002);
        bus(1'h1, 8'h04, 32'h8000_0000);
        bus(1'h1, 8'h04, 32'h1020_3084);
        bus(1'h1, 8'h04, 32'h2030_4084);
        key(32'h2030_4084, 16'h0, 1'h1);
        key(32'h1020_3084, 16'h0, 1'h1);
        key(32'h1030_4010, 16'h0005, 1'h1);
        key(32'h1030_4010, 16'h0, 1'h0);
        key(32'h2130_4084, 16'h0, 1'h0);
        key(32'h1020_30fc, 16'h0, 1'h0);
        @(posedge clk);
        sgn <= 1'h1;
        key(32'h1020_30fc, 16'h0, 1'h1);
        // Alpha is absent: it gets the full sign-magnitude range.
        bus(1'h1, 8'h04, 32'h7904_0002);
        bus(1'h1, 8'h04, 32'h8000_0000);
        bus(1'h1, 8'h04, 32'hff20_3084);
        bus(1'h1, 8'h04, 32'h7f30_4084);
        key(32'hab20_30fc, 16'h0, 1'h1);
    endtask
    task automatic t_pal();
        bus(1'h1, 8'h04, 32'h7902_0002);
        bus(1'h1, 8'h04, 32'haabb_ccdd);
        bus(1'h1, 8'h04, 32'h1122_3344);
        bus(1'h1, 8'h04, 32'h5566_7788);
        pal(8'h00, 32'haabb_ccdd);
        pal(8'h02, 32'h5566_7788);
    endtask
    task automatic t_reject();
        bus(1'h1, 8'h04, 32'h1911_0000);
        bus(1'h1, 8'h04, 32'h7911_0000);
        bus(1'h1, 8'h04, 32'h7905_0000);
        bus(1'h1, 8'h04, 32'h7911_0000);
        bus(1'h1, 8'h04, 32'h7911_0000);
        bus(1'h1, 8'h04, 32'h0000_0009);
        bus(1'h0, 8'h08, 32'h0002_0501);
        bus(1'h0, 8'h0c, 32'h0000_0009);
        bus(1'h0, 8'h20, 32'h0);
    endtask
    task automatic t_border();
        @(posedge clk);
        fill <= 1'h1;
        @(posedge clk);
        fill <= 1'h0;
        repeat (14) @(posedge clk);
        brd(3'h1, 4'h8, 0, 0, 32'h11, 32'h22, 32'h33, 32'h44);
        bus(1'h1, 8'h00, 32'h1);
        brd(3'h1, 4'h9, 0, 0, 32'h0, 32'h4635_2413, 32'h4736_2514,
            aux_state_pkg::ONE_FLOAT32);
        brd(3'h1, 4'h0, 1, 0, 32'h4534_2312, 32'h4534_2312, 32'h4534_2312,
            32'h4837_2615);
        brd(3'h1, 4'h0, 0, 1, 32'h4534_2312, 32'h4534_2312, 32'h4534_2312,
            32'h4534_2312);
        brd(3'h3, 4'h0, 0, 0, 32'h2918, 32'h4b3a, 32'h2a19, 32'h4c3b);
        bus(1'h1, 8'h00, 32'h3);
        brd(3'h1, 4'h0, 0, 0, 32'h0, 32'h0, 32'h0, 32'h0);
        @(posedge clk);
        oob <= 1'h1;
        cube <= 1'h1;
        repeat (2) @(posedge clk);
        #1 `CHK("use_border", 1'h0, ub)
        @(posedge clk);
        fdis <= 1'h1;
        oob <= 1'h0;
        repeat (2) @(posedge clk);
        #1 `CHK("use_border", 1'h1, ub)
        @(posedge clk);
        cube <= 1'h0;
        oob <= 1'h1;
        repeat (2) @(posedge clk);
        #1 `CHK("use_border", 1'h1, ub)
    endtask
    task automatic test_done();
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        t_kernel();
        t_key();
        t_pal();
        t_reject();
        t_border();
        test_done();
    end
endmodule
`default_nettype wire
